/* hw/sar_adc_sequencer.sv */
// Control, sequencing and APB registers of the 8-bit SAR converter.
// ------------------------------------------------------------
// Summary of operation
// - The result is 8 bits; inputs at or above the high reference give FFh without overflow, at or below the low give 00h.
// - Each conversion is a sample-load phase then 8 approximation cycles with the sample switch open.
// - While on, load and conversion repeat continuously on the selected channel.
// - One conversion lasts 12 converter clocks, the converter clock being half the bus clock.
// - Bits 3 to 0 choose analog input n by binary code n, 0 to 15.
// - Setting bit 5 powers the converter and starts a conversion; clearing it turns it off.
// - At the end of each conversion bit 7 is set, and no interrupt exists.
// - The result register keeps its value until the next conversion finishes.
// - A write to the control/status register while on aborts, clears the flag and restarts.
// - The flag clears on a result read or a control/status write and cannot be set by software.
// - Wait mode has no effect; halt mode disables the converter.
// - Analog input pins stay readable as logic inputs during conversion.
// - After reset the control/status register reads 00h.
// - The result register is read-only, resets to 00h and a read clears the flag.
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer #(
    parameter int result_width = 8,
    parameter int channels = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_mode,
    input wire logic comparator_high,
    input wire logic [channels-1:0] analog_input_pin,
    output logic [channels-1:0] port_input_value,
    output logic [result_width-1:0] dac_trial,
    output logic [3:0] analog_channel,
    output logic sample_switch_closed,
    output logic converter_power
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam logic [3:0] last_load = 4'(sar_adc_pkg::load_periods - 1);
    localparam logic [3:0] last_approx = 4'(sar_adc_pkg::approx_periods - 1);
    sar_adc_pkg::seq_state_e state;
    sar_adc_pkg::seq_state_e next_state;
    logic [3:0] period;
    logic [3:0] next_period;
    logic adc_tick;
    logic next_adc_tick;
    logic converter_power_on;
    logic next_converter_power_on;
    logic conversion_done_flag;
    logic next_conversion_done_flag;
    logic [3:0] channel_select;
    logic [3:0] next_channel_select;
    logic [7:0] converter_result_reg;
    logic [7:0] next_converter_result_reg;
    logic [31:0] next_prdata;
    logic next_pslverr;
    logic access;
    logic wr_csr;
    logic rd_result;
    logic active;
    logic sar_start;
    logic sar_step;
    logic finish;
    logic [result_width-1:0] sar_code;
    logic [result_width-1:0] sar_trial;

    // APB decode of the access phase; the slave answers with zero wait states.
    assign access = psel && penable;
    assign wr_csr = access && pwrite && paddr == sar_adc_pkg::control_status_addr;
    assign rd_result = access && !pwrite && paddr == sar_adc_pkg::result_addr;
    // Halt forces the converter idle; wait mode is not an input at all.
    assign active = converter_power_on && !halt_mode;

    // ------------------------------------------------------------
    // Converter clock enable
    // ------------------------------------------------------------
    // Divide by two: one enable pulse every second bus clock.
    always_comb begin
        next_adc_tick = active ? !adc_tick : 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_tick <= 1'b0;
        end else begin
            adc_tick <= next_adc_tick;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    // Four load periods then eight approximation periods, repeated while on.
    assign finish = adc_tick && state == sar_adc_pkg::approx_st && period == last_approx;
    assign sar_start = adc_tick && state == sar_adc_pkg::load_st && period == last_load;
    assign sar_step = adc_tick && state == sar_adc_pkg::approx_st;

    always_comb begin
        next_state = state;
        next_period = period;
        if (!active) begin
            next_state = sar_adc_pkg::off_st;
            next_period = '0;
        end else if (wr_csr || state == sar_adc_pkg::off_st) begin
            next_state = sar_adc_pkg::load_st;
            next_period = '0;
        end else if (adc_tick) begin
            case (state)
                sar_adc_pkg::load_st: begin
                    if (period == last_load) begin
                        next_state = sar_adc_pkg::approx_st;
                        next_period = '0;
                    end else begin
                        next_period = period + 4'h1;
                    end
                end
                sar_adc_pkg::approx_st: begin
                    if (period == last_approx) begin
                        next_state = sar_adc_pkg::load_st;
                        next_period = '0;
                    end else begin
                        next_period = period + 4'h1;
                    end
                end
                default: begin
                    next_state = sar_adc_pkg::off_st;
                    next_period = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= sar_adc_pkg::off_st;
            period <= '0;
        end else begin
            state <= next_state;
            period <= next_period;
        end
    end

    // Bit-by-bit approximation; saturation falls out naturally at 00h and FFh.
    sar_adc_step #(
        .width(result_width)
    ) i_sar_adc_step (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .step(sar_step),
        .comparator_high(comparator_high),
        .code(sar_code),
        .trial(sar_trial)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Flag set wins over a result-read clear in the same cycle, a control/status write wins over the set; software bit 7 is ignored.
    always_comb begin
        next_converter_power_on = converter_power_on;
        next_channel_select = channel_select;
        next_conversion_done_flag = conversion_done_flag;
        next_converter_result_reg = converter_result_reg;
        if (wr_csr) begin
            next_converter_power_on = pwdata[sar_adc_pkg::power_bit];
            next_channel_select = pwdata[sar_adc_pkg::channel_lsb +: 4];
        end
        if (wr_csr || rd_result) begin
            next_conversion_done_flag = 1'b0;
        end
        if (finish && !wr_csr) begin
            next_conversion_done_flag = 1'b1;
            next_converter_result_reg = {sar_code[7:1], sar_code[0] | comparator_high & ~sar_code[0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            converter_power_on <= 1'b0;
            channel_select <= '0;
            conversion_done_flag <= 1'b0;
            converter_result_reg <= sar_adc_pkg::result_reset;
        end else begin
            converter_power_on <= next_converter_power_on;
            channel_select <= next_channel_select;
            conversion_done_flag <= next_conversion_done_flag;
            converter_result_reg <= next_converter_result_reg;
        end
    end

    // Read mux; reserved bits 6 and 4 read as zero, unmapped reads return zero with an error.
    always_comb begin
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            next_prdata = '0;
            if (paddr == sar_adc_pkg::control_status_addr) begin
                next_prdata[7:0] = {conversion_done_flag, 1'b0, converter_power_on, 1'b0, channel_select};
            end else if (paddr == sar_adc_pkg::result_addr) begin
                next_prdata[7:0] = converter_result_reg;
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            pready <= psel && !penable;
        end
    end

    // ------------------------------------------------------------
    // Analog front-end controls
    // ------------------------------------------------------------
    // Pins pass through as digital readings regardless of conversion.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_input_value <= '0;
            dac_trial <= '0;
            analog_channel <= '0;
            sample_switch_closed <= 1'b0;
            converter_power <= 1'b0;
        end else begin
            port_input_value <= analog_input_pin;
            dac_trial <= sar_trial;
            analog_channel <= next_channel_select;
            sample_switch_closed <= next_state == sar_adc_pkg::load_st;
            converter_power <= next_converter_power_on && !halt_mode;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Checks on the tick, the flag, the result and the sequencer.
    a_tick_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
        adc_tick |=> !adc_tick) else $error("converter tick not at half rate.");
    a_flag_on_finish: assert property (@(posedge pclk) disable iff (!presetn)
        finish && !wr_csr |=> conversion_done_flag) else $error("flag not set at finish.");
    a_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !finish |=> $stable(converter_result_reg)) else $error("result changed early.");
    a_write_clears: assert property (@(posedge pclk) disable iff (!presetn)
        wr_csr |=> !conversion_done_flag) else $error("write did not clear flag.");
    a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
        rd_result && !finish |=> !conversion_done_flag) else $error("read did not clear flag.");
    a_halt_stops: assert property (@(posedge pclk) disable iff (!presetn)
        halt_mode |=> state == sar_adc_pkg::off_st) else $error("halt did not stop converter.");
    a_restart_load: assert property (@(posedge pclk) disable iff (!presetn)
        converter_power_on && wr_csr && pwdata[sar_adc_pkg::power_bit] && !halt_mode
        |=> state == sar_adc_pkg::load_st && period == 4'h0) else $error("write did not restart.");
    // Every finish lies exactly eight converter clocks after the start of approximation.
    a_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
        finish |-> $past(sar_start, 16)) else $error("approximation length wrong.");
    a_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !converter_power_on |=> !sample_switch_closed) else $error("switch closed while off.");
    c_finish: cover property (@(posedge pclk) disable iff (!presetn) finish);
    c_abort: cover property (@(posedge pclk) disable iff (!presetn)
        wr_csr && state == sar_adc_pkg::approx_st);
    c_read_flag: cover property (@(posedge pclk) disable iff (!presetn) rd_result && conversion_done_flag);
endmodule : sar_adc_sequencer
`default_nettype wire

/* hw/sar_adc_step.sv */
// Successive-approximation register: one trial bit per approximation step.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_step #(
    parameter int width = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic step,
    input wire logic comparator_high,
    output logic [width-1:0] code,
    output logic [width-1:0] trial
);
    logic [width-1:0] next_code;
    logic [width-1:0] next_trial;
    logic [width-1:0] mask;
    logic [width-1:0] next_mask;

    // Trial code driven to the DAC is the kept bits plus the bit under test.
    assign trial = code | mask;

    // Start clears the code and points at the MSB; each step keeps or drops the tested bit.
    always_comb begin
        next_code = code;
        next_mask = mask;
        if (start) begin
            next_code = '0;
            next_mask = {1'b1, {(width-1){1'b0}}};
        end else if (step && mask != '0) begin
            if (comparator_high) begin
                next_code = code | mask;
            end
            next_mask = mask >> 1;
        end
    end

    // Registers of the approximation.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code <= '0;
            mask <= '0;
        end else begin
            code <= next_code;
            mask <= next_mask;
        end
    end
endmodule : sar_adc_step
`default_nettype wire

/* shared/sar_adc_pkg.sv */
// Package with register map, field layout, reset values and timing for the SAR converter sequencer.
package sar_adc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // Offsets 70h and 71h are word indices: the byte address is four times the index.
    localparam logic [7:0] result_index = 8'h70;
    localparam logic [7:0] control_status_index = 8'h71;
    localparam logic [11:0] result_addr = {2'h0, result_index, 2'h0};
    localparam logic [11:0] control_status_addr = {2'h0, control_status_index, 2'h0};
    localparam int addr_width = 12;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int done_bit = 7;
    localparam int power_bit = 5;
    localparam int channel_lsb = 0;
    localparam int channel_width = 4;
    localparam int result_width = 8;
    localparam logic [7:0] control_status_reset = 8'h00;
    localparam logic [7:0] result_reset = 8'h00;
    localparam logic [7:0] full_scale = 8'hFF;
    // ------------------------------------------------------------
    // Timing in converter clock periods
    // ------------------------------------------------------------
    localparam int cpu_per_adc_clock = 2;
    localparam int conversion_periods = 12;
    localparam int approx_periods = 8;
    localparam int load_periods = conversion_periods - approx_periods;
    typedef enum logic [1:0] {off_st, load_st, approx_st} seq_state_e;
endpackage : sar_adc_pkg

/* verif/sar_adc_sequencer_tb.sv */
// Self-checking testbench for the SAR converter sequencer.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_tb;
    // ------------------------------------------------------------
    // Signals, clock and comparator
    // ------------------------------------------------------------
    typedef struct {logic [3:0] ch; logic [7:0] vin;} row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic halt_mode = 1'b0;
    logic comparator_high;
    logic [15:0] analog_input_pin = 16'h0000;
    logic [15:0] port_input_value;
    logic [7:0] dac_trial;
    logic [3:0] analog_channel;
    logic sample_switch_closed;
    logic converter_power;
    logic [7:0] vin = 8'h00;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    int k;
    row_s rows [4] = '{'{4'h0, 8'h00}, '{4'hF, 8'hFF}, '{4'h5, 8'h5A}, '{4'hA, 8'hA5}};
    localparam logic [11:0] cs = sar_adc_pkg::control_status_addr;
    localparam logic [11:0] res = sar_adc_pkg::result_addr;

    // Clock at 100 MHz.
    always #5 pclk = ~pclk;

    // Ideal analog comparator: high while the input is at or above the trial code.
    assign comparator_high = (vin >= dac_trial);

    sar_adc_sequencer i_sar_adc_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .halt_mode(halt_mode), .comparator_high(comparator_high), .analog_input_pin(analog_input_pin),
        .port_input_value(port_input_value), .dac_trial(dac_trial), .analog_channel(analog_channel),
        .sample_switch_closed(sample_switch_closed), .converter_power(converter_power));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Prints the verdict and ends the run.
    task automatic conclude;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; holds the request until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Polls the status register until the completion flag shows.
    task automatic wait_flag;
        int n;
        n = 0;
        do begin
            apb(1'b0, cs, 32'h0000_0000);
            n++;
        end while (rd[7] !== 1'b1 && n < 40);
        check(32'(rd[7]), 32'h0000_0001);
    endtask : wait_flag

    // Counts the cycles for which the sample switch keeps the given level.
    task automatic phase_len(input logic lvl);
        k = 0;
        while (sample_switch_closed === lvl && k < 100) begin
            @(posedge pclk);
            k++;
        end
    endtask : phase_len

    // Cuts a hang short.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cs, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b0, res, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // Every channel code drives the multiplexer select.
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, cs, 32'h0000_0020 | 32'(c));
            repeat (2) @(posedge pclk);
            check(32'(analog_channel), 32'(c));
        end
        // Table of conversions: channel and input level against the expected result.
        foreach (rows[i]) begin
            vin <= rows[i].vin;
            apb(1'b1, cs, 32'h0000_0020 | 32'(rows[i].ch));
            repeat (2) @(posedge pclk);
            check(32'(converter_power), 32'h0000_0001);
            wait_flag();
            apb(1'b0, res, 32'h0000_0000);
            check(rd, 32'(rows[i].vin));
            apb(1'b0, cs, 32'h0000_0000);
            check(rd, 32'h0000_0020 | 32'(rows[i].ch));
        end
        // A restart keeps the old result until the new conversion ends.
        vin <= 8'h33;
        apb(1'b1, cs, 32'h0000_002A);
        apb(1'b0, cs, 32'h0000_0000);
        check(rd, 32'h0000_002A);
        apb(1'b0, res, 32'h0000_0000);
        check(rd, 32'h0000_00A5);
        wait_flag();
        apb(1'b0, res, 32'h0000_0000);
        check(rd, 32'h0000_0033);
        // Phase lengths of repeated conversions in bus clock cycles.
        phase_len(1'b1);
        phase_len(1'b0);
        phase_len(1'b1);
        check(32'(k), 32'h0000_0008);
        phase_len(1'b0);
        check(32'(k), 32'h0000_0010);
        phase_len(1'b1);
        check(32'(k), 32'h0000_0008);
        // Pin levels stay readable while converting.
        analog_input_pin <= 16'hA5C3;
        repeat (3) @(posedge pclk);
        check(32'(port_input_value), 32'h0000_A5C3);
        // Halt stops the converter but keeps the power bit.
        halt_mode <= 1'b1;
        apb(1'b1, cs, 32'h0000_0020);
        repeat (40) @(posedge pclk);
        check(32'(converter_power), 32'h0000_0000);
        apb(1'b0, cs, 32'h0000_0000);
        check(rd, 32'h0000_0020);
        halt_mode <= 1'b0;
        wait_flag();
        // Switching off, and a write of the flag bit that must not set it.
        apb(1'b1, cs, 32'h0000_0080);
        repeat (40) @(posedge pclk);
        check(32'(converter_power), 32'h0000_0000);
        check(32'(sample_switch_closed), 32'h0000_0000);
        apb(1'b0, cs, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        // An unmapped address is refused and leaves the registers alone.
        apb(1'b1, 12'h000, 32'h0000_0025);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, 12'h000, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check(32'(err), 32'h0000_0001);
        apb(1'b0, cs, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        conclude();
    end
endmodule : sar_adc_sequencer_tb
`default_nettype wire
